// ===== pufs_consts.svh
// Constants for the process unit feature selectors
`ifndef PUFS_CONSTS_SVH
`define PUFS_CONSTS_SVH
// Register byte offsets
`define PUFS_OFF_CTRL     12'h000
`define PUFS_OFF_SPLIT    12'h004
`define PUFS_OFF_CHAR     12'h008
`define PUFS_OFF_LATCH    12'h00C
`define PUFS_OFF_LAMPS    12'h010
`define PUFS_OFF_TRACK    12'h014
`define PUFS_OFF_MEMADR   12'h018
`define PUFS_OFF_MEMDAT   12'h01C
// CTRL fields
`define PUFS_CTRL_DISP    0
// Character selector destination address code (-99)
`define PUFS_CHAR_SEL_ADR 8'hE3
// Character bit positions: 1 2 4 8 0 X parity
`define PUFS_BIT_0        4
`define PUFS_BIT_X        5
// Extra track character codes (bits X,0,8,4,2,1)
`define PUFS_TRK_U        6'h14
`define PUFS_TRK_SLASH    6'h11
`define PUFS_TRK_PERIOD   6'h3B
`define PUFS_TRK_POUND    6'h0B
// Reset value and AXI response codes
`define PUFS_RST_SPLIT    2'h0
`define PUFS_AXI_OKAY     2'h0
`define PUFS_AXI_SLVERR   2'h2
`endif

// ===== pufs_pkg.sv
// Types for the process unit feature selectors
package pufs_pkg;
  typedef enum logic [1:0] {
    PUFS_SRC_EXIT,
    PUFS_SRC_START,
    PUFS_SRC_DELAY,
    PUFS_SRC_CTRL
  } pufs_src_t;
  typedef enum {
    PUFS_B_IDLE,
    PUFS_B_RESP
  } pufs_bst_t;
endpackage : pufs_pkg

// ===== pufs_trk_if.sv
// Carrier between the top and the extra track store
interface pufs_trk_if #(parameter int AW = 10);
  logic          we;
  logic [1:0]    trk;
  logic [AW-1:0] adr;
  logic [7:0]    wdat;
  logic [7:0]    rdat;
  modport ctl (output we, output trk, output adr, output wdat, input rdat);
  modport mem (input we, input trk, input adr, input wdat, output rdat);
endinterface : pufs_trk_if

// ===== pufs_trk_mem.sv
// Four extra working-storage drum tracks
module pufs_trk_mem #(
  parameter int AW = 10
) (
  input wire logic aclk,
  input wire logic ce,
  pufs_trk_if.mem  bus
);
  logic [7:0] mem_r [0:4*(1<<AW)-1];
  logic [7:0] rdat_r;
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (bus.we) begin
        mem_r[{bus.trk, bus.adr}] <= bus.wdat;
      end
      rdat_r <= mem_r[{bus.trk, bus.adr}];
    end
  end
  assign bus.rdat = rdat_r;
endmodule : pufs_trk_mem

// ===== pufs_top.sv
// Feature selector logic of the process unit
// Functional notes
// - Two split groups: alphabetic, numeric plus special
// - Each group emits on one row only
// - Upper pickup keeps upper row until lower
// - Lower pickup keeps lower row until upper
// - Row switch waits for next program exit
// - Pickups accept exit, start, delay, control
// - Special pair left hub is upper row
// - Only aresetn resets selected split row, to upper
// - Zone selectors act on character selector address
// - Zone 12 both, X only X, 0 only 0
// - Credit X over zero transfers both
// - Latch selectors 31-40 with group reset
// - Display switch moves lights 1-10 to 31-40
// - Two lamps show displayed selector range
// - Decode four extra working-storage track codes
`include "pufs_consts.svh"
module pufs_top #(
  parameter int NLATCH = 10,
  parameter int TRK_AW = 10
) (
  aclk,
  aresetn,
  ce,
  prog_exit,
  exit_code,
  pick_up,
  pick_lo,
  pick_src,
  instr_valid,
  to_adr,
  char_in,
  sel_1_30,
  latch_pick,
  latch_reset,
  trk_valid,
  trk_code,
  trk_we,
  trk_adr,
  trk_wdat,
  exit_alpha_up,
  exit_alpha_lo,
  exit_num_up,
  exit_num_lo,
  zone_x,
  zone_0,
  lights,
  lamp_1_30,
  lamp_31_40,
  trk_hit,
  trk_rdat,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_awaddr,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_bresp,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_araddr,
  s_axi_rvalid,
  s_axi_rready,
  s_axi_rdata,
  s_axi_rresp
);
  input  wire logic              aclk;
  input  wire logic              aresetn;
  input  wire logic              ce;
  input  wire logic              prog_exit;
  input  wire logic [5:0]        exit_code;
  input  wire logic [1:0]        pick_up;
  input  wire logic [1:0]        pick_lo;
  input  wire pufs_pkg::pufs_src_t pick_src;
  input  wire logic              instr_valid;
  input  wire logic [7:0]        to_adr;
  input  wire logic [6:0]        char_in;
  input  wire logic [29:0]       sel_1_30;
  input  wire logic [NLATCH-1:0] latch_pick;
  input  wire logic              latch_reset;
  input  wire logic              trk_valid;
  input  wire logic [5:0]        trk_code;
  input  wire logic              trk_we;
  input  wire logic [TRK_AW-1:0] trk_adr;
  input  wire logic [7:0]        trk_wdat;
  output logic                   exit_alpha_up;
  output logic                   exit_alpha_lo;
  output logic                   exit_num_up;
  output logic                   exit_num_lo;
  output logic                   zone_x;
  output logic                   zone_0;
  output logic [29:0]            lights;
  output logic                   lamp_1_30;
  output logic                   lamp_31_40;
  output logic                   trk_hit;
  output logic [7:0]             trk_rdat;
  input  wire logic              s_axi_awvalid;
  output logic                   s_axi_awready;
  input  wire logic [11:0]       s_axi_awaddr;
  input  wire logic              s_axi_wvalid;
  output logic                   s_axi_wready;
  input  wire logic [31:0]       s_axi_wdata;
  input  wire logic [3:0]        s_axi_wstrb;
  output logic                   s_axi_bvalid;
  input  wire logic              s_axi_bready;
  output logic [1:0]             s_axi_bresp;
  input  wire logic              s_axi_arvalid;
  output logic                   s_axi_arready;
  input  wire logic [11:0]       s_axi_araddr;
  output logic                   s_axi_rvalid;
  input  wire logic              s_axi_rready;
  output logic [31:0]            s_axi_rdata;
  output logic [1:0]             s_axi_rresp;

  if (NLATCH != 10) begin : g_bad_nlatch
    $error("NLATCH must be 10");
  end
  if (TRK_AW < 1 || TRK_AW > 12) begin : g_bad_aw
    $error("TRK_AW out of range");
  end

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [1:0]        row_lo;
    logic [1:0]        pend_up;
    logic [1:0]        pend_lo;
    logic              ex_au;
    logic              ex_al;
    logic              ex_nu;
    logic              ex_nl;
    logic              zx;
    logic              z0;
    logic [NLATCH-1:0] latch;
    logic              disp;
    logic [29:0]       lights;
    logic              lamp_lo;
    logic              lamp_hi;
    logic              hit;
    logic [1:0]        trk_sel;
    logic [TRK_AW-1:0] madr;
    logic              awok;
    logic              wok;
    logic [11:0]       awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              mwe;
    logic [7:0]        mwdat;
  } pufs_st_t;
  pufs_st_t st_r;
  pufs_st_t st_nxt;

  // Track code decode, used for the drum path; software access sets the track directly
  function automatic logic [2:0] trk_dec(input logic [5:0] c);
    unique case (c)
      `PUFS_TRK_U:      trk_dec = 3'h4;
      `PUFS_TRK_SLASH:  trk_dec = 3'h5;
      `PUFS_TRK_PERIOD: trk_dec = 3'h6;
      `PUFS_TRK_POUND:  trk_dec = 3'h7;
      default:          trk_dec = 3'h0;
    endcase
  endfunction : trk_dec

  // Letters carry a zone and a digit 1-9; slash (0-1) is special
  function automatic logic is_alpha(input logic [5:0] c);
    is_alpha = (c[5:4] != 2'h0) && (c[3:0] != 4'h0) &&
               (c[3:0] <= 4'h9) && (c != `PUFS_TRK_SLASH);
  endfunction : is_alpha

  pufs_trk_if #(.AW(TRK_AW)) tif ();
  pufs_trk_mem #(.AW(TRK_AW)) u_mem (
    .aclk (aclk),
    .ce   (ce),
    .bus  (tif.mem)
  );
  assign tif.we   = st_r.mwe;
  assign tif.trk  = st_r.trk_sel;
  assign tif.adr  = st_r.madr;
  assign tif.wdat = st_r.mwdat;

  logic [2:0] dec_w;
  assign dec_w = trk_dec(trk_code);

  always_comb begin
    logic [1:0]  up_now;
    logic [1:0]  lo_now;
    logic        grp;
    logic        wr_go;
    logic [31:0] rd;
    st_nxt = st_r;
    up_now = 2'h0;
    lo_now = 2'h0;
    grp    = 1'b0;
    wr_go  = 1'b0;
    rd     = 32'h0;
    st_nxt.mwe = 1'b0;
    // ***************************************************
    // Split program exits
    // ***************************************************
    // Any pickup source is accepted alike
    up_now = pick_up | st_r.pend_up;
    lo_now = pick_lo | st_r.pend_lo;
    st_nxt.ex_au = 1'b0;
    st_nxt.ex_al = 1'b0;
    st_nxt.ex_nu = 1'b0;
    st_nxt.ex_nl = 1'b0;
    // Only an exit moves a row; machine resets have no path here
    if (prog_exit) begin
      // Pending pickups take effect just before this exit
      for (int g = 0; g < 2; g++) begin
        if (lo_now[g]) st_nxt.row_lo[g] = 1'b1;
        else if (up_now[g]) st_nxt.row_lo[g] = 1'b0;
      end
      st_nxt.pend_up = 2'h0;
      st_nxt.pend_lo = 2'h0;
      // Alphabetic group 0, numeric and special group 1
      grp = !is_alpha(exit_code);
      // Left special hub is upper row: same encoding
      if (!grp) begin
        st_nxt.ex_au = !st_nxt.row_lo[0];
        st_nxt.ex_al = st_nxt.row_lo[0];
      end else begin
        st_nxt.ex_nu = !st_nxt.row_lo[1];
        st_nxt.ex_nl = st_nxt.row_lo[1];
      end
    end else begin
      // Latest pickup of a group wins while waiting
      for (int g = 0; g < 2; g++) begin
        if (pick_lo[g]) begin
          st_nxt.pend_lo[g] = 1'b1;
          st_nxt.pend_up[g] = 1'b0;
        end else if (pick_up[g]) begin
          st_nxt.pend_up[g] = 1'b1;
          st_nxt.pend_lo[g] = 1'b0;
        end
      end
    end
    // ***************************************************
    // Zone bit selectors
    // ***************************************************
    if (instr_valid && to_adr == `PUFS_CHAR_SEL_ADR) begin
      // Zone 12 has both bits, credit X over zero likewise
      st_nxt.zx = char_in[`PUFS_BIT_X];
      st_nxt.z0 = char_in[`PUFS_BIT_0];
    end
    // ***************************************************
    // Latch group and console display
    // ***************************************************
    if (latch_reset) st_nxt.latch = '0;
    else st_nxt.latch = st_r.latch | latch_pick;
    st_nxt.lights = sel_1_30;
    if (st_r.disp) st_nxt.lights[NLATCH-1:0] = st_r.latch;
    st_nxt.lamp_lo = !st_r.disp;
    st_nxt.lamp_hi = st_r.disp;
    // ***************************************************
    // Extra drum tracks
    // ***************************************************
    st_nxt.hit = trk_valid && dec_w[2];
    if (trk_valid && dec_w[2]) begin
      st_nxt.trk_sel = dec_w[1:0];
      st_nxt.madr    = trk_adr;
      st_nxt.mwe     = trk_we;
      st_nxt.mwdat   = trk_wdat;
    end
    // ***************************************************
    // AXI4-Lite slave
    // ***************************************************
    if (s_axi_awvalid && !st_r.awok && !st_r.bvalid) begin
      st_nxt.awok   = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wok && !st_r.bvalid) begin
      st_nxt.wok   = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    wr_go = st_r.awok && st_r.wok && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.awok   = 1'b0;
      st_nxt.wok    = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `PUFS_AXI_OKAY;
      unique case (st_r.awaddr)
        `PUFS_OFF_CTRL:
          if (st_r.wstrb[0]) st_nxt.disp = st_r.wdata[`PUFS_CTRL_DISP];
        `PUFS_OFF_MEMADR:
          if (!(trk_valid && dec_w[2])) begin
            st_nxt.trk_sel = st_r.wdata[17:16];
            st_nxt.madr    = st_r.wdata[TRK_AW-1:0];
          end
        `PUFS_OFF_MEMDAT:
          if (st_r.wstrb[0] && !(trk_valid && dec_w[2])) begin
            st_nxt.mwe   = 1'b1;
            st_nxt.mwdat = st_r.wdata[7:0];
          end
        `PUFS_OFF_SPLIT, `PUFS_OFF_CHAR, `PUFS_OFF_LATCH,
        `PUFS_OFF_LAMPS, `PUFS_OFF_TRACK: ;
        default: st_nxt.bresp = `PUFS_AXI_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    st_nxt.arready = 1'b0;
    if (s_axi_arvalid && !st_r.arready && !st_r.rvalid) begin
      st_nxt.arready = 1'b1;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = `PUFS_AXI_OKAY;
      unique case (s_axi_araddr)
        `PUFS_OFF_CTRL:   rd = {31'h0, st_r.disp};
        `PUFS_OFF_SPLIT:  rd = {26'h0, st_r.pend_lo, st_r.pend_up,
                                st_r.row_lo};
        `PUFS_OFF_CHAR:   rd = {30'h0, st_r.zx, st_r.z0};
        `PUFS_OFF_LATCH:  rd = {22'h0, st_r.latch};
        `PUFS_OFF_LAMPS:  rd = {st_r.lamp_hi, st_r.lamp_lo, st_r.lights};
        `PUFS_OFF_TRACK:  rd = {29'h0, st_r.hit, st_r.trk_sel};
        `PUFS_OFF_MEMADR: rd = {14'h0, st_r.trk_sel,
                                16'(st_r.madr)};
        `PUFS_OFF_MEMDAT: rd = {24'h0, tif.rdat};
        default:          st_nxt.rresp = `PUFS_AXI_SLVERR;
      endcase
      st_nxt.rdata = rd;
    end
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.lamp_lo <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign exit_alpha_up = st_r.ex_au;
  assign exit_alpha_lo = st_r.ex_al;
  assign exit_num_up   = st_r.ex_nu;
  assign exit_num_lo   = st_r.ex_nl;
  assign zone_x        = st_r.zx;
  assign zone_0        = st_r.z0;
  assign lights        = st_r.lights;
  assign lamp_1_30     = st_r.lamp_lo;
  assign lamp_31_40    = st_r.lamp_hi;
  assign trk_hit       = st_r.hit;
  assign trk_rdat      = tif.rdat;
  assign s_axi_awready = st_r.awok;
  assign s_axi_wready  = st_r.wok;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  // ***************************************************
  // Checks
  // ***************************************************
  chk_rows_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    !(exit_alpha_up && exit_alpha_lo) && !(exit_num_up && exit_num_lo))
    else $error("both rows emit");
  chk_no_early_switch: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !prog_exit) |=> $stable(st_r.row_lo))
    else $error("row switched without exit");
  chk_lower_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && prog_exit && (pick_lo[0] || st_r.pend_lo[0]))
    |=> st_r.row_lo[0])
    else $error("lower pickup ignored");
  chk_upper_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && prog_exit && (pick_up[1] || st_r.pend_up[1]) && !pick_lo[1] &&
     !st_r.pend_lo[1]) |=> !st_r.row_lo[1])
    else $error("upper pickup ignored");
  chk_zone_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && instr_valid && to_adr == `PUFS_CHAR_SEL_ADR)
    |=> zone_x == $past(char_in[`PUFS_BIT_X]) &&
        zone_0 == $past(char_in[`PUFS_BIT_0]))
    else $error("zone selectors wrong");
  chk_latch_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && latch_reset) |=> st_r.latch == '0)
    else $error("latch reset failed");
  chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !latch_reset && (latch_pick[0] || st_r.latch[0]))
    |=> st_r.latch[0])
    else $error("latch did not hold");
  chk_lamps_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (lamp_1_30 != lamp_31_40))
    else $error("range lamps wrong");
  chk_display_mux: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_r.disp) |=> lights[NLATCH-1:0] == $past(st_r.latch))
    else $error("display mux wrong");
  chk_track_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && trk_valid && trk_code == `PUFS_TRK_POUND) |=> trk_hit)
    else $error("track not decoded");
endmodule : pufs_top

// ===== pufs_tb_plug.sv
// Stored program and plugboard model driving program exits and pickups
module pufs_tb_plug (
  input  wire logic           aclk,
  output logic                prog_exit,
  output logic [5:0]          exit_code,
  output logic [1:0]          pick_up,
  output logic [1:0]          pick_lo,
  output pufs_pkg::pufs_src_t pick_src
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    prog_exit = 1'b0;
    exit_code = 6'h00;
    pick_up   = 2'h0;
    pick_lo   = 2'h0;
    pick_src  = pufs_pkg::PUFS_SRC_EXIT;
  end

  // One-cycle pickup impulse from any of the four sources
  task automatic pickup(input logic [1:0] up, input logic [1:0] lo,
                        input pufs_pkg::pufs_src_t src);
    @(posedge aclk);
    pick_up  <= up;
    pick_lo  <= lo;
    pick_src <= src;
    @(posedge aclk);
    pick_up  <= 2'h0;
    pick_lo  <= 2'h0;
  endtask : pickup

  // Rows set by a start impulse before the job runs
  task automatic job_start();
    pickup(2'h3, 2'h0, pufs_pkg::PUFS_SRC_START);
  endtask : job_start

  // Program exit after an optional idle gap; code line scrambled after
  task automatic issue(input logic [5:0] code, input int gap);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    prog_exit <= 1'b1;
    exit_code <= code;
    @(posedge aclk);
    prog_exit <= 1'b0;
    exit_code <= ~code;
  endtask : issue
endmodule : pufs_tb_plug

// ===== tb.sv
// Self-checking bench for the process unit feature selectors
`include "pufs_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, instr_valid = 1'b0;
  logic [7:0] to_adr = 8'h00, trk_wdat = 8'h00, trk_rdat;
  logic [6:0] char_in = 7'h00;
  logic [29:0] sel_1_30 = 30'h2AAAAAAA, lights;
  logic [9:0] latch_pick = 10'h000, trk_adr = 10'h000;
  logic latch_reset = 1'b0, trk_valid = 1'b0, trk_we = 1'b0;
  logic [5:0] trk_code = 6'h00, exit_code;
  logic prog_exit, exit_alpha_up, exit_alpha_lo, exit_num_up, exit_num_lo;
  logic zone_x, zone_0, lamp_1_30, lamp_31_40, trk_hit;
  logic [1:0] pick_up, pick_lo;
  pufs_pkg::pufs_src_t pick_src;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] codes [4] = '{`PUFS_TRK_U, `PUFS_TRK_SLASH,
                            `PUFS_TRK_PERIOD, `PUFS_TRK_POUND};
  int fails = 0;
  int checked = 0;

  always #25 aclk = ~aclk;

  pufs_top dut (.aclk, .aresetn, .ce, .prog_exit, .exit_code, .pick_up,
    .pick_lo, .pick_src, .instr_valid, .to_adr, .char_in, .sel_1_30,
    .latch_pick, .latch_reset, .trk_valid, .trk_code, .trk_we, .trk_adr,
    .trk_wdat, .exit_alpha_up, .exit_alpha_lo, .exit_num_up, .exit_num_lo,
    .zone_x, .zone_0, .lights, .lamp_1_30, .lamp_31_40, .trk_hit, .trk_rdat,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  pufs_tb_plug plug (.aclk, .prog_exit, .exit_code, .pick_up, .pick_lo,
    .pick_src);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 1000;
      end
    end
    check(32'(n), 32'h3E8);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 1000;
      end
    end
    check(32'(n), 32'h3E8);
  endtask : axi_rd

  // Issues an exit and gathers every row pulse over three cycles
  task automatic exit_chk(input logic [5:0] code, input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    plug.issue(code, 1);
    repeat (3) begin
      #1;
      seen = seen | {exit_alpha_up, exit_alpha_lo, exit_num_up, exit_num_lo};
      @(posedge aclk);
    end
    check(32'(seen), 32'(exp));
  endtask : exit_chk

  task automatic zone_chk(input logic [7:0] adr, input logic [6:0] ch,
                          input logic [1:0] exp);
    @(posedge aclk);
    instr_valid <= 1'b1;
    to_adr      <= adr;
    char_in     <= ch;
    @(posedge aclk);
    instr_valid <= 1'b0;
    char_in     <= ~ch;
    @(posedge aclk);
    #1;
    check(32'({zone_x, zone_0}), 32'(exp));
  endtask : zone_chk

  task automatic trk_op(input logic [5:0] c, input logic we,
                        input logic [7:0] d, output logic hit);
    @(posedge aclk);
    trk_valid <= 1'b1;
    trk_code  <= c;
    trk_we    <= we;
    trk_adr   <= 10'h005;
    trk_wdat  <= d;
    hit = 1'b0;
    @(posedge aclk);
    trk_valid <= 1'b0;
    trk_we    <= 1'b0;
    repeat (3) begin
      #1;
      hit = hit | trk_hit;
      @(posedge aclk);
    end
  endtask : trk_op

  task automatic latch_pulse(input logic [9:0] pk, input logic clr);
    @(posedge aclk);
    latch_pick  <= pk;
    latch_reset <= clr;
    @(posedge aclk);
    latch_pick  <= 10'h000;
    latch_reset <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : latch_pulse

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_sim();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic h;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check(32'({lamp_1_30, lamp_31_40}), 32'h2);
    axi_rd(`PUFS_OFF_CTRL);
    check(rd, 32'h0);
    axi_rd(12'h020);
    check(32'(rs), 32'(`PUFS_AXI_SLVERR));
    $display("test registers done");
    plug.job_start();
    exit_chk(6'h21, 4'h8);
    exit_chk(6'h05, 4'h2);
    for (int i = 0; i < 4; i++) begin
      if (i[0]) plug.pickup(2'h1, 2'h0, pufs_pkg::pufs_src_t'(i));
      else plug.pickup(2'h0, 2'h1, pufs_pkg::pufs_src_t'(i));
      exit_chk(6'h05, 4'h2);
      exit_chk(6'h21, i[0] ? 4'h8 : 4'h4);
      exit_chk(6'h21, i[0] ? 4'h8 : 4'h4);
    end
    plug.pickup(2'h0, 2'h2, pufs_pkg::PUFS_SRC_CTRL);
    axi_rd(`PUFS_OFF_SPLIT);
    check(rd, 32'h20);
    exit_chk(6'h0B, 4'h1);
    plug.pickup(2'h2, 2'h0, pufs_pkg::PUFS_SRC_EXIT);
    exit_chk(6'h0B, 4'h2);
    exit_chk(6'h3B, 4'h2);
    exit_chk(6'h11, 4'h2);
    $display("test split done");
    zone_chk(`PUFS_CHAR_SEL_ADR, 7'h31, 2'h3);
    zone_chk(`PUFS_CHAR_SEL_ADR, 7'h21, 2'h2);
    zone_chk(`PUFS_CHAR_SEL_ADR, 7'h11, 2'h1);
    zone_chk(`PUFS_CHAR_SEL_ADR, 7'h30, 2'h3);
    zone_chk(8'h12, 7'h01, 2'h3);
    zone_chk(`PUFS_CHAR_SEL_ADR, 7'h01, 2'h0);
    $display("test zone done");
    axi_wr(`PUFS_OFF_CTRL, 32'h1);
    axi_rd(`PUFS_OFF_CTRL);
    check(rd, 32'h1);
    latch_pulse(10'h201, 1'b0);
    check(32'(lights), 32'({sel_1_30[29:10], 10'h201}));
    check(32'({lamp_1_30, lamp_31_40}), 32'h1);
    latch_pulse(10'h002, 1'b0);
    check(32'(lights[9:0]), 32'h203);
    axi_wr(`PUFS_OFF_CTRL, 32'h0);
    repeat (2) @(posedge aclk);
    #1;
    check(32'(lights), 32'(sel_1_30));
    axi_rd(`PUFS_OFF_LAMPS);
    check(32'(rd[31:30]), 32'h1);
    latch_pulse(10'h000, 1'b1);
    axi_wr(`PUFS_OFF_CTRL, 32'h1);
    repeat (2) @(posedge aclk);
    #1;
    check(32'(lights[9:0]), 32'h0);
    latch_pulse(10'h004, 1'b1);
    check(32'(lights[9:0]), 32'h0);
    $display("test latch done");
    for (int i = 0; i < 4; i++) begin
      trk_op(codes[i], 1'b1, 8'hA0 + 8'(i), h);
      check(32'(h), 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      trk_op(codes[i], 1'b0, 8'h00, h);
      check(32'(h), 32'h1);
      check(32'(trk_rdat), 32'hA0 + i);
    end
    trk_op(6'h21, 1'b0, 8'h00, h);
    check(32'(h), 32'h0);
    $display("test track done");
    end_sim();
  end
endmodule : tb
